// File: src/dsos_pkg.sv
// Purpose: Shared constants and carrier types for the drive status output selector.
// Assumes: 20 MHz ref_clk; frequencies in 0.01 Hz units; delays in 0.01 s units.
// Notes: Register offsets are byte addresses on a 32-bit APB slave.
package dsos_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int FREQ_W = 16;
  localparam int DLY_W = 14;
  localparam int SEL_W = 5;
  localparam int ADDR_W = 8;
  localparam int TICK_W = 18;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_KHZ = 20000;
  localparam int TICK_MS = 10;
  // Clock cycles per delay tick: kHz times ms gives cycles
  localparam int TICK_CYCLES = REF_CLK_KHZ * TICK_MS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DET_FREQ = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DET_BAND = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_GEN_ON = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GEN_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FLT_ON = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FLT_OFF = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_TMR_ON = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TMR_OFF = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SEL_RELAY_LSB = 0;
  localparam int SEL_XO_LSB = 8;
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_POL_LSB = 4;
  localparam int POL_RELAY = 0;
  localparam int POL_XO = 1;
  localparam logic [SEL_W-1:0] RST_RELAY_SEL = 5'h1D;
  localparam logic [SEL_W-1:0] RST_XO_SEL = 5'h0E;
  localparam logic [2:0] RST_FAULT_MASK = 3'h2;
  localparam logic [FREQ_W-1:0] RST_DET_FREQ = 16'h0BB8;
  localparam logic [FREQ_W-1:0] RST_DET_BAND = 16'h03E8;

  // ----------------------------------------------------------------
  // Output selector codes
  // ----------------------------------------------------------------
  localparam int C_FREQ_REACH = 1;
  localparam int C_FREQ_MATCH = 2;
  localparam int C_FREQ_WINDOW = 3;
  localparam int C_FREQ_HYST = 4;
  localparam int C_MOTOR_OVL = 5;
  localparam int C_DRIVE_OVL = 6;
  localparam int C_UNDERLOAD = 7;
  localparam int C_FAN_WARN = 8;
  localparam int C_STALL = 9;
  localparam int C_OVER_VOLT = 10;
  localparam int C_UNDER_VOLT = 11;
  localparam int C_OVER_HEAT = 12;
  localparam int C_CMD_LOST = 13;
  localparam int C_RUN = 14;
  localparam int C_STOP = 15;
  localparam int C_STEADY = 16;
  localparam int C_DRIVE_LINE = 17;
  localparam int C_MAINS_LINE = 18;
  localparam int C_SPEED_SEARCH = 19;
  localparam int C_READY = 22;
  localparam int C_TIMER = 28;
  localparam logic [SEL_W-1:0] C_FAULT = 5'h1D;

  // ----------------------------------------------------------------
  // Drive core status carrier (same clock as ref_clk)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FREQ_W-1:0] set_freq;
    logic [FREQ_W-1:0] out_freq;
    logic [FREQ_W-1:0] oper_freq;
    logic accel, decel, run_cmd, volt_out, dc_brake;
    logic motor_ovl, drive_overload_flag, underload, fan_warn, stall;
    logic over_volt, under_volt, over_heat, analog_lost, comm_lost;
    logic speed_search, tripped;
    logic uv_trip, other_trip, restart_exhausted, fault_reset;
  } dsos_status_t;

endpackage

// File: src/dsos_selector.sv
// Purpose: Drives the relay and transistor outputs from a selectable drive status condition.
// Assumes: Status struct comes from logic on ref_clk; terminal inputs are asynchronous.
// Notes: Delays count a 10 ms tick, so a delay is exact to within one tick.
//
// What this block does
// R1: Code 1 on while |set - output freq| below half band.
// R2: Code 2 needs code 1 and |set - detect freq| below half band.
// R3: Code 3 on while |output - operation freq| below half band.
// R4: Code 4 turns on when operation freq reaches detect freq.
// R5: Code 4 stays on while operation freq above detect minus half band.
// R6: Codes 5, 6, 7 route motor overload, drive overload, underload flags.
// R7: Code 8 follows the cooling fan warning.
// R8: Code 9 follows the motor stall flag.
// R9: Codes 10 and 11 follow DC link over and under voltage.
// R10: Code 12 follows heat sink overtemperature.
// R11: Code 13 on when analog or serial command is lost.
// R12: Code 14 on with run command and output voltage, off in DC braking.
// R13: Code 15 on when run command off and no output voltage.
// R14: Code 16 on at constant speed, not accelerating or decelerating.
// R15: Codes 17 and 18 show drive line and mains line, set by transfer input.
// R16: Code 19 on while speed search is active.
// R17: Code 22 on when not tripped and waiting for run command.
// R18: Code 28 follows timer input after its own on and off delays.
// R19: Code 29 selects the fault output; relay defaults 29, transistor 14.
// R20: Three-bit fault class mask, reset 010, qualifies the fault output.
// R21: Fault output turns on only after the fault on delay.
// R22: After fault reset the fault output turns off after the off delay.
// R23: Polarity bit per output: 0 normally open, 1 normally closed.
// R24: General delays apply to both outputs except when fault selected.
// R25: All delays count a 10 ms tick derived from the clock.
// R26: Undefined selector codes hold the output inactive before polarity.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

module dsos_selector #(
  parameter int TICK_CYCLES = dsos_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dsos_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive core status
  input wire dsos_pkg::dsos_status_t drive_status,
  // Terminal inputs, asynchronous
  input wire logic timer_in_pin,
  input wire logic line_xfer_pin,
  // Contact outputs
  output logic relay_output,
  output logic transistor_output
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [dsos_pkg::SEL_W-1:0] relay_sel;
    logic [dsos_pkg::SEL_W-1:0] xo_sel;
    logic [2:0] fault_mask;
    logic [1:0] polarity;
    logic [dsos_pkg::FREQ_W-1:0] detect_freq_setpoint;
    logic [dsos_pkg::FREQ_W-1:0] detect_freq_band;
    logic [dsos_pkg::DLY_W-1:0] gen_on;
    logic [dsos_pkg::DLY_W-1:0] gen_off;
    logic [dsos_pkg::DLY_W-1:0] fault_on_delay;
    logic [dsos_pkg::DLY_W-1:0] fault_off_delay;
    logic [dsos_pkg::DLY_W-1:0] delay_timer_on_time;
    logic [dsos_pkg::DLY_W-1:0] delay_timer_off_time;
    logic [dsos_pkg::TICK_W-1:0] tick_cnt;
    logic tick;
    logic [1:0] timer_sync;
    logic [1:0] xfer_sync;
    logic timer_out;
    logic [dsos_pkg::DLY_W-1:0] timer_cnt;
    logic fault_latched;
    logic fault_out;
    logic [dsos_pkg::DLY_W-1:0] fault_cnt;
    logic freq_hyst;
    logic relay_dly;
    logic [dsos_pkg::DLY_W-1:0] relay_cnt;
    logic xo_dly;
    logic [dsos_pkg::DLY_W-1:0] xo_cnt;
    logic relay_pin;
    logic xo_pin;
    logic [31:0] rdata;
    logic rerr;
  } dsos_state_t;

  dsos_state_t st;
  dsos_state_t next_st;
  logic [31:0] cond;
  logic [dsos_pkg::FREQ_W-1:0] half_band;
  logic [dsos_pkg::FREQ_W-1:0] hyst_low;
  logic fault_raw;
  logic raw_relay;
  logic raw_xo;
  logic relay_is_fault;
  logic xo_is_fault;
  logic apb_wr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Unsigned distance between two frequencies, no wrap
  function automatic logic [dsos_pkg::FREQ_W-1:0] absdiff(
    input logic [dsos_pkg::FREQ_W-1:0] a,
    input logic [dsos_pkg::FREQ_W-1:0] b
  );
    return (a > b) ? (a - b) : (b - a);
  endfunction

  // One step of an on/off delay: returns {output, tick count}.
  // A level that flips back before the delay ends restarts the count.
  function automatic logic [dsos_pkg::DLY_W:0] delay_step(
    input logic cur,
    input logic target,
    input logic tick,
    input logic [dsos_pkg::DLY_W-1:0] cnt,
    input logic [dsos_pkg::DLY_W-1:0] on_dly,
    input logic [dsos_pkg::DLY_W-1:0] off_dly
  );
    logic [dsos_pkg::DLY_W-1:0] need;
    need = target ? on_dly : off_dly;
    if (target == cur) begin
      return {cur, {dsos_pkg::DLY_W{1'b0}}};
    end else if (cnt >= need) begin
      return {target, {dsos_pkg::DLY_W{1'b0}}};
    end else if (tick) begin
      return {cur, cnt + 1'b1};
    end else begin
      return {cur, cnt};
    end
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    apb_wr = psel & penable & pwrite;

    // R25: tick divider
    if (st.tick_cnt == dsos_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
      next_st.tick = 1'b0;
    end

    // Terminal pins pass two flops before use
    next_st.timer_sync = {st.timer_sync[0], timer_in_pin};
    next_st.xfer_sync = {st.xfer_sync[0], line_xfer_pin};

    half_band = st.detect_freq_band >> 1;
    // Clamp at zero so a small setpoint cannot wrap the low threshold
    if (st.detect_freq_setpoint > half_band) begin
      hyst_low = st.detect_freq_setpoint - half_band;
    end else begin
      hyst_low = '0;
    end

    // R4: set once operation frequency reaches detect frequency
    // R5: hold until it falls to detect minus half band
    if (st.freq_hyst) begin
      next_st.freq_hyst = drive_status.oper_freq > hyst_low;
    end else begin
      next_st.freq_hyst = drive_status.oper_freq >= st.detect_freq_setpoint;
    end

    // R26: codes with no function stay low
    cond = '0;
    // R1: reach window
    cond[dsos_pkg::C_FREQ_REACH] = absdiff(drive_status.set_freq,
                                           drive_status.out_freq) < half_band;
    // R2: reach plus setpoint match
    cond[dsos_pkg::C_FREQ_MATCH] = cond[dsos_pkg::C_FREQ_REACH] &
        (absdiff(drive_status.set_freq, st.detect_freq_setpoint) < half_band);
    // R3: output versus operation frequency
    cond[dsos_pkg::C_FREQ_WINDOW] = absdiff(drive_status.out_freq,
                                            drive_status.oper_freq) < half_band;
    cond[dsos_pkg::C_FREQ_HYST] = st.freq_hyst;
    // R6: overload and underload flags
    cond[dsos_pkg::C_MOTOR_OVL] = drive_status.motor_ovl;
    cond[dsos_pkg::C_DRIVE_OVL] = drive_status.drive_overload_flag;
    cond[dsos_pkg::C_UNDERLOAD] = drive_status.underload;
    // R7: fan warning
    cond[dsos_pkg::C_FAN_WARN] = drive_status.fan_warn;
    // R8: stall
    cond[dsos_pkg::C_STALL] = drive_status.stall;
    // R9: DC link levels
    cond[dsos_pkg::C_OVER_VOLT] = drive_status.over_volt;
    cond[dsos_pkg::C_UNDER_VOLT] = drive_status.under_volt;
    // R10: heat sink
    cond[dsos_pkg::C_OVER_HEAT] = drive_status.over_heat;
    // R11: lost command
    cond[dsos_pkg::C_CMD_LOST] = drive_status.analog_lost | drive_status.comm_lost;
    // R12: running, blanked during DC braking
    cond[dsos_pkg::C_RUN] = drive_status.run_cmd & drive_status.volt_out &
                            ~drive_status.dc_brake;
    // R13: fully stopped
    cond[dsos_pkg::C_STOP] = ~drive_status.run_cmd & ~drive_status.volt_out;
    // R14: steady speed only while actually running
    cond[dsos_pkg::C_STEADY] = drive_status.run_cmd & drive_status.volt_out &
                               ~drive_status.accel & ~drive_status.decel;
    // R15: line transfer input picks drive or mains line
    cond[dsos_pkg::C_DRIVE_LINE] = ~st.xfer_sync[1];
    cond[dsos_pkg::C_MAINS_LINE] = st.xfer_sync[1];
    // R16: speed search
    cond[dsos_pkg::C_SPEED_SEARCH] = drive_status.speed_search;
    // R17: healthy and idle
    cond[dsos_pkg::C_READY] = ~drive_status.tripped & ~drive_status.run_cmd;
    cond[dsos_pkg::C_TIMER] = st.timer_out;
    // R19: fault output as a selectable source
    cond[dsos_pkg::C_FAULT] = st.fault_out;

    // R18: timer input with its own on and off delays
    {next_st.timer_out, next_st.timer_cnt} = delay_step(st.timer_out,
        st.timer_sync[1], st.tick, st.timer_cnt, st.delay_timer_on_time,
        st.delay_timer_off_time);

    // R20: fault classes gated by the mask
    fault_raw = |(st.fault_mask & {drive_status.restart_exhausted,
                                   drive_status.other_trip, drive_status.uv_trip});
    // R22: reset clears the latch; a fault in the same cycle wins
    next_st.fault_latched = fault_raw | (st.fault_latched & ~drive_status.fault_reset);
    // R21: fault output delays
    {next_st.fault_out, next_st.fault_cnt} = delay_step(st.fault_out,
        st.fault_latched, st.tick, st.fault_cnt, st.fault_on_delay, st.fault_off_delay);

    relay_is_fault = st.relay_sel == dsos_pkg::C_FAULT;
    xo_is_fault = st.xo_sel == dsos_pkg::C_FAULT;
    raw_relay = cond[st.relay_sel];
    raw_xo = cond[st.xo_sel];

    // R24: general delays, bypassed when the output carries the fault
    {next_st.relay_dly, next_st.relay_cnt} = delay_step(st.relay_dly, raw_relay,
        st.tick, st.relay_cnt, relay_is_fault ? '0 : st.gen_on,
        relay_is_fault ? '0 : st.gen_off);
    {next_st.xo_dly, next_st.xo_cnt} = delay_step(st.xo_dly, raw_xo,
        st.tick, st.xo_cnt, xo_is_fault ? '0 : st.gen_on,
        xo_is_fault ? '0 : st.gen_off);

    // R23: contact type applied last
    next_st.relay_pin = next_st.relay_dly ^ st.polarity[dsos_pkg::POL_RELAY];
    next_st.xo_pin = next_st.xo_dly ^ st.polarity[dsos_pkg::POL_XO];

    // Register writes take effect in the access phase
    if (apb_wr) begin
      case (paddr)
        dsos_pkg::OFS_SELECT: begin
          next_st.relay_sel = pwdata[dsos_pkg::SEL_RELAY_LSB +: dsos_pkg::SEL_W];
          next_st.xo_sel = pwdata[dsos_pkg::SEL_XO_LSB +: dsos_pkg::SEL_W];
        end
        dsos_pkg::OFS_CONFIG: begin
          next_st.fault_mask = pwdata[dsos_pkg::CFG_MASK_LSB +: 3];
          next_st.polarity = pwdata[dsos_pkg::CFG_POL_LSB +: 2];
        end
        dsos_pkg::OFS_DET_FREQ: next_st.detect_freq_setpoint = pwdata[dsos_pkg::FREQ_W-1:0];
        dsos_pkg::OFS_DET_BAND: next_st.detect_freq_band = pwdata[dsos_pkg::FREQ_W-1:0];
        dsos_pkg::OFS_GEN_ON: next_st.gen_on = pwdata[dsos_pkg::DLY_W-1:0];
        dsos_pkg::OFS_GEN_OFF: next_st.gen_off = pwdata[dsos_pkg::DLY_W-1:0];
        dsos_pkg::OFS_FLT_ON: next_st.fault_on_delay = pwdata[dsos_pkg::DLY_W-1:0];
        dsos_pkg::OFS_FLT_OFF: next_st.fault_off_delay = pwdata[dsos_pkg::DLY_W-1:0];
        dsos_pkg::OFS_TMR_ON: next_st.delay_timer_on_time = pwdata[dsos_pkg::DLY_W-1:0];
        dsos_pkg::OFS_TMR_OFF: next_st.delay_timer_off_time = pwdata[dsos_pkg::DLY_W-1:0];
        default: begin
        end
      endcase
    end

    // Read data is latched in the setup phase so the access phase needs no wait
    if (psel & ~penable) begin
      next_st.rdata = '0;
      next_st.rerr = 1'b0;
      case (paddr)
        dsos_pkg::OFS_SELECT: begin
          next_st.rdata[dsos_pkg::SEL_RELAY_LSB +: dsos_pkg::SEL_W] = st.relay_sel;
          next_st.rdata[dsos_pkg::SEL_XO_LSB +: dsos_pkg::SEL_W] = st.xo_sel;
        end
        dsos_pkg::OFS_CONFIG: begin
          next_st.rdata[dsos_pkg::CFG_MASK_LSB +: 3] = st.fault_mask;
          next_st.rdata[dsos_pkg::CFG_POL_LSB +: 2] = st.polarity;
        end
        dsos_pkg::OFS_DET_FREQ: next_st.rdata[dsos_pkg::FREQ_W-1:0] = st.detect_freq_setpoint;
        dsos_pkg::OFS_DET_BAND: next_st.rdata[dsos_pkg::FREQ_W-1:0] = st.detect_freq_band;
        dsos_pkg::OFS_GEN_ON: next_st.rdata[dsos_pkg::DLY_W-1:0] = st.gen_on;
        dsos_pkg::OFS_GEN_OFF: next_st.rdata[dsos_pkg::DLY_W-1:0] = st.gen_off;
        dsos_pkg::OFS_FLT_ON: next_st.rdata[dsos_pkg::DLY_W-1:0] = st.fault_on_delay;
        dsos_pkg::OFS_FLT_OFF: next_st.rdata[dsos_pkg::DLY_W-1:0] = st.fault_off_delay;
        dsos_pkg::OFS_TMR_ON: next_st.rdata[dsos_pkg::DLY_W-1:0] = st.delay_timer_on_time;
        dsos_pkg::OFS_TMR_OFF: next_st.rdata[dsos_pkg::DLY_W-1:0] = st.delay_timer_off_time;
        dsos_pkg::OFS_STATUS: next_st.rdata[6:0] = {st.freq_hyst, st.xfer_sync[1],
            st.fault_latched, st.timer_out, st.fault_out, st.xo_pin, st.relay_pin};
        default: next_st.rerr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.relay_sel <= dsos_pkg::RST_RELAY_SEL;
      st.xo_sel <= dsos_pkg::RST_XO_SEL;
      st.fault_mask <= dsos_pkg::RST_FAULT_MASK;
      st.detect_freq_setpoint <= dsos_pkg::RST_DET_FREQ;
      st.detect_freq_band <= dsos_pkg::RST_DET_BAND;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; zero-wait slave
  assign relay_output = st.relay_pin;
  assign transistor_output = st.xo_pin;
  assign prdata = st.rdata;
  assign pslverr = st.rerr;
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dsos_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  tick_period_a: assert property ( // R25
    st.tick |-> (st.tick_cnt == '0) &&
        ($past(st.tick_cnt) == dsos_pkg::TICK_W'(TICK_CYCLES - 1))
  ) else $error("delay tick off its period");

  hyst_reach_a: assert property ( // R4
    (!st.freq_hyst && drive_status.oper_freq >= st.detect_freq_setpoint) |=> st.freq_hyst
  ) else $error("hysteresis flag missed reach");

  hyst_hold_a: assert property ( // R5
    (st.freq_hyst && drive_status.oper_freq > hyst_low) |=> st.freq_hyst
  ) else $error("hysteresis flag dropped early");

  fault_latch_a: assert property ( // R20
    (|(st.fault_mask & {drive_status.restart_exhausted, drive_status.other_trip,
        drive_status.uv_trip})) |=> st.fault_latched
  ) else $error("enabled fault not latched");

  fault_on_dly_a: assert property ( // R21
    $rose(st.fault_out) |-> $past(st.fault_latched) &&
        ($past(st.fault_cnt) >= $past(st.fault_on_delay))
  ) else $error("fault output rose before its delay");

  fault_off_dly_a: assert property ( // R22
    $fell(st.fault_out) |-> !$past(st.fault_latched) &&
        ($past(st.fault_cnt) >= $past(st.fault_off_delay))
  ) else $error("fault output fell early");

  timer_on_dly_a: assert property ( // R18
    $rose(st.timer_out) |-> $past(st.timer_sync[1]) &&
        ($past(st.timer_cnt) >= $past(st.delay_timer_on_time))
  ) else $error("timer output rose before its delay");

  relay_follow_a: assert property ( // R24
    (st.gen_on == '0 && st.gen_off == '0 && !relay_is_fault && !apb_wr)
        |=> relay_output == ($past(raw_relay) ^ st.polarity[dsos_pkg::POL_RELAY])
  ) else $error("relay did not follow its source");

  xo_fault_path_a: assert property ( // R19
    (xo_is_fault && !apb_wr) ##1 (xo_is_fault && !apb_wr)
        |-> transistor_output == ($past(st.fault_out) ^ st.polarity[dsos_pkg::POL_XO])
  ) else $error("transistor output not following fault output");

  undef_code_a: assert property ( // R26
    ((st.xo_sel == 5'h14 || st.xo_sel == 5'h00) && st.gen_off == '0) |=> !st.xo_dly
  ) else $error("undefined code drove the output");

  slverr_a: assert property (
    (psel && !penable && paddr > dsos_pkg::OFS_STATUS) |=> pslverr
  ) else $error("unmapped address not flagged");

endmodule

// File: sim/dsos_core_model.sv
// Purpose: Behavioural stand-in for the drive control core feeding the selector.
// Assumes: Bench sets the wanted status levels; they appear one edge later.
// Notes: Registered so that status never changes inside a clock edge's settling.
`timescale 1ns/10ps
module dsos_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wanted levels and what the selector sees
  input wire dsos_pkg::dsos_status_t cmd,
  output dsos_pkg::dsos_status_t status
);
  // Core levels change only at the rising edge, as the real core's would
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= cmd;
    end
  end
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the drive status output selector.
// Assumes: Delay tick shortened to 4 clocks; core modelled by dsos_core_model.
// Notes: Row table covers plain codes; polarity, delays, fault and reset follow.
`timescale 1ns/10ps
module tb_top;
  typedef struct {int c; int s; int o; int p; logic [20:0] f; logic e;} dsos_row_t;
  localparam int TK = 4;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic timer_in_pin = 0, line_xfer_pin = 0, relay_output, transistor_output;
  dsos_pkg::dsos_status_t cmd = '0, drive_status;
  int err_total = 0, checks = 0;
  // Code, set/output/operation freq, flag bits, expected output
  dsos_row_t rows[34] = '{'{1,3000,2600,0,21'h0,1}, '{1,3000,2500,0,21'h0,0},
    '{2,3000,3000,0,21'h0,1}, '{2,3600,3600,0,21'h0,0}, '{3,0,3000,3499,21'h0,1},
    '{3,0,3000,3500,21'h0,0}, '{4,0,0,3000,21'h0,1}, '{4,0,0,2600,21'h0,1},
    '{4,0,0,2500,21'h0,0}, '{4,0,0,2999,21'h0,0}, '{5,0,0,0,21'h08000,1},
    '{5,0,0,0,21'h07FFF,0}, '{6,0,0,0,21'h04000,1}, '{7,0,0,0,21'h02000,1},
    '{8,0,0,0,21'h01000,1}, '{9,0,0,0,21'h00800,1}, '{10,0,0,0,21'h00400,1},
    '{11,0,0,0,21'h00200,1}, '{12,0,0,0,21'h00100,1}, '{13,0,0,0,21'h00080,1},
    '{13,0,0,0,21'h00040,1}, '{14,0,0,0,21'h60000,1}, '{14,0,0,0,21'h70000,0},
    '{15,0,0,0,21'h0,1}, '{15,0,0,0,21'h40000,0}, '{16,0,0,0,21'h60000,1},
    '{16,0,0,0,21'h160000,0}, '{19,0,0,0,21'h00020,1}, '{22,0,0,0,21'h0,1},
    '{22,0,0,0,21'h00010,0}, '{0,0,0,0,21'h1FFFE,0}, '{20,0,0,0,21'h1FFFE,0},
    '{17,0,0,0,21'h0,1}, '{18,0,0,0,21'h0,0}};

  dsos_selector #(.TICK_CYCLES(TK)) uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_status(drive_status),
    .timer_in_pin(timer_in_pin), .line_xfer_pin(line_xfer_pin),
    .relay_output(relay_output), .transistor_output(transistor_output));
  dsos_core_model core (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .status(drive_status));

  always #25 ref_clk = ~ref_clk;

  task automatic results();
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        err_total++;
        results();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Bounded wait for the relay to reach a level
  task automatic wait_rly(input logic v);
    int n;
    n = 0;
    while (relay_output !== v) begin
      @(posedge ref_clk);
      n++;
      if (n > 40) begin
        err_total++;
        results();
      end
    end
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    foreach (rows[i]) begin
      apb(1, dsos_pkg::OFS_SELECT, {19'h0, 5'(rows[i].c), 3'h0, 5'(rows[i].c)});
      cmd.set_freq <= 16'(rows[i].s);
      cmd.out_freq <= 16'(rows[i].o);
      cmd.oper_freq <= 16'(rows[i].p);
      cmd[20:0] <= rows[i].f;
      repeat (4) @(posedge ref_clk);
      chk("relay row", relay_output, rows[i].e);
      chk("transistor row", transistor_output, rows[i].e);
    end
    // Polarity bit per output, transistor only inverted
    apb(1, dsos_pkg::OFS_CONFIG, 32'h00000022);
    apb(1, dsos_pkg::OFS_SELECT, 32'h00000000);
    repeat (4) @(posedge ref_clk);
    chk("relay pol", relay_output, 0);
    chk("transistor pol", transistor_output, 1);
    apb(1, dsos_pkg::OFS_CONFIG, 32'h00000002);
    // General on delay of two ticks on a plain code
    apb(1, dsos_pkg::OFS_GEN_ON, 32'h2);
    apb(1, dsos_pkg::OFS_SELECT, 32'h00000505);
    cmd[20:0] <= 21'h08000;
    repeat (5) @(posedge ref_clk);
    chk("general delay", relay_output, 0);
    wait_rly(1);
    apb(1, dsos_pkg::OFS_GEN_ON, 32'h0);
    // Fault output: each mask bit, its delays and a masked class
    apb(1, dsos_pkg::OFS_FLT_ON, 32'h2);
    apb(1, dsos_pkg::OFS_FLT_OFF, 32'h1);
    apb(1, dsos_pkg::OFS_SELECT, 32'h00001D1D);
    for (int i = 0; i < 3; i++) begin
      apb(1, dsos_pkg::OFS_CONFIG, 32'(1 << i));
      cmd[20:0] <= 21'(1 << (3 - ((i + 1) % 3))) | 21'h1;
      repeat (16) @(posedge ref_clk);
      chk("masked fault", relay_output, 0);
      cmd[20:0] <= 21'(1 << (3 - i));
      repeat (5) @(posedge ref_clk);
      chk("fault on delay", relay_output, 0);
      wait_rly(1);
      chk("fault transistor", transistor_output, 1);
      cmd[20:0] <= 21'h1;
      repeat (5) @(posedge ref_clk);
      chk("fault off delay", relay_output, 1);
      wait_rly(0);
    end
    // Timer input with its own on delay
    cmd[20:0] <= 21'h0;
    apb(1, dsos_pkg::OFS_TMR_ON, 32'h2);
    apb(1, dsos_pkg::OFS_SELECT, 32'h00001C1C);
    timer_in_pin <= 1;
    repeat (5) @(posedge ref_clk);
    chk("timer delay", relay_output, 0);
    wait_rly(1);
    // Timer input falls; output holds for its own off delay
    apb(1, dsos_pkg::OFS_TMR_OFF, 32'h2);
    timer_in_pin <= 0;
    repeat (5) @(posedge ref_clk);
    chk("timer off delay", relay_output, 1);
    wait_rly(0);
    // Line transfer pin moves the output from code 17 to code 18
    apb(1, dsos_pkg::OFS_SELECT, 32'h00001212);
    line_xfer_pin <= 1;
    wait_rly(1);
    apb(1, dsos_pkg::OFS_SELECT, 32'h00001111);
    repeat (4) @(posedge ref_clk);
    chk("inverter line", relay_output, 0);
    // Mid-run reset restores defaults
    apb(1, dsos_pkg::OFS_CONFIG, 32'h00000035);
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    chk("relay reset", relay_output, 0);
    apb(0, dsos_pkg::OFS_SELECT, 32'h0);
    chk("select reset", rd, 32'h00000E1D);
    apb(0, dsos_pkg::OFS_CONFIG, 32'h0);
    chk("config reset", rd, 32'h00000002);
    apb(0, 8'h2C, 32'h0);
    chk("unmapped error", {31'h0, rerr}, 32'h1);
    results();
  end
endmodule
